// file: kbs_matrix.sv
`default_nettype none
module kbs_matrix
	import kbs_pkg::*;
(
	input  wire logic [17:0] row_out,
	input  wire logic [17:0] row_oe,
	input  wire logic [4:0]  key_row,
	input  wire logic [2:0]  key_col,
	input  wire logic        key_down,
	output var  logic [7:0]  col_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [17:0] row_lvl;
	// Released rows float up to the pull-up level
	assign row_lvl = (row_out & row_oe) | ~row_oe;
	// A closed switch pulls its column to the row level, else pull-up
	always_comb begin
		col_out = 8'hFF;
		if (key_down && !row_lvl[key_row])
			col_out[key_col] = 1'b0;
	end
endmodule : kbs_matrix
`default_nettype wire

// file: kbs_pkg.sv
`default_nettype none
package kbs_pkg;
	// Register byte offsets
	localparam logic [7:0]  OFS_ROW_SEL  = 8'h04;
	localparam logic [7:0]  OFS_COL_IN   = 8'h08;
	localparam logic [7:0]  OFS_COL_STS  = 8'h0C;
	localparam logic [7:0]  OFS_COL_IEN  = 8'h10;
	localparam logic [7:0]  OFS_EXT_CTL  = 8'h14;
	// Row select and external control field positions
	localparam int          POS_SEL_LSB  = 0;
	localparam int          POS_ALL      = 5;
	localparam int          POS_DIS      = 6;
	localparam int          POS_INV      = 7;
	localparam int          POS_PD_EN    = 0;
	// Reset values and highest row index
	localparam logic [4:0]  RST_SEL      = 5'h00;
	localparam logic        RST_DIS      = 1'b1;
	localparam logic [7:0]  RST_IEN      = 8'h00;
	localparam logic [4:0]  ROW_MAX      = 5'h11;
	// Predrive high time
	localparam int          CLK_NS       = 50;
	localparam int          PD_NS        = 100;
	localparam logic [1:0]  PD_CYC       = 2'((PD_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {
		ST_LP   = 3'h1,
		ST_SCAN = 3'h2,
		ST_PRED = 3'h4
	} kbs_st_t;

	typedef struct packed {
		kbs_st_t     st;
		logic [7:0]  col_meta;
		logic [7:0]  col_sync;
		logic [7:0]  col_prev;
		logic [4:0]  sel;
		logic        all;
		logic        dis;
		logic        inv;
		logic        pd_en;
		logic [7:0]  sts;
		logic [7:0]  ien;
		logic        irq;
		logic        armed;
		logic        wake;
		logic [17:0] low;
		logic [17:0] pd_rows;
		logic [1:0]  pd_cnt;
		logic [31:0] rdata;
		logic [17:0] out;
		logic [17:0] oe;
	} kbs_regs_t;
endpackage : kbs_pkg
`default_nettype wire

// file: kbs_scan.sv
`default_nettype none
module kbs_scan
	import kbs_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output var  logic [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [7:0]  COLUMN_SENSE_IN,
	output var  logic [17:0] ROW_DRIVE_OUT,
	output var  logic [17:0] ROW_DRIVE_OE,
	input  wire logic        BUS_CLK_STOPPED,
	output var  logic        SCAN_RUNTIME_IRQ,
	output var  logic        SCAN_WAKE_IRQ,
	output logic             SLEEP_INHIBIT
);
	kbs_regs_t   r;
	kbs_regs_t   n;
	logic [7:0]  fall;
	logic [17:0] tgt;
	logic [17:0] rel;
	logic        wr;

	// Mapped offset check
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == OFS_ROW_SEL) || (a == OFS_COL_IN) || (a == OFS_COL_STS) ||
			(a == OFS_COL_IEN) || (a == OFS_EXT_CTL);
	endfunction : addr_ok

	// Rows to pull low from select, all, invert and disable
	function automatic logic [17:0] row_low(input kbs_regs_t s);
		logic [17:0] v;
		v = 18'h00000;
		if (s.dis) begin
			v = 18'h00000;
		end else if (s.sel > ROW_MAX) begin
			v = s.inv ? 18'h3FFFF : 18'h00000;
		end else if (s.all) begin
			v = s.inv ? 18'h00000 : 18'h3FFFF;
		end else if (!s.inv) begin
			v = 18'h00001 << s.sel;
		end
		row_low = v;
	endfunction : row_low

	assign wr = PSEL & PENABLE & PWRITE;
	assign fall = r.col_prev & ~r.col_sync;
	assign tgt = row_low(r);
	assign rel = r.low & ~tgt;

	// Zero-wait access; unmapped offsets raise an error
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~addr_ok(PADDR);
	assign SLEEP_INHIBIT = (r.st != ST_LP);

	// Next-state logic
	always_comb begin
		n = r;
		// Two-stage column synchroniser
		n.col_meta = COLUMN_SENSE_IN;
		n.col_sync = r.col_meta;
		n.col_prev = r.col_sync;
		// Register writes
		if (wr) begin
			case (PADDR)
				OFS_ROW_SEL: begin
					n.sel = PWDATA[POS_SEL_LSB +: 5];
					n.all = PWDATA[POS_ALL];
					n.dis = PWDATA[POS_DIS];
					n.inv = PWDATA[POS_INV];
				end
				OFS_COL_STS: begin
					n.sts = r.sts & ~PWDATA[7:0];
				end
				OFS_COL_IEN: begin
					n.ien = PWDATA[7:0];
				end
				OFS_EXT_CTL: begin
					n.pd_en = PWDATA[POS_PD_EN];
				end
				default: begin
					n.sts = r.sts;
				end
			endcase
		end
		// Falling edge sets status, winning over a clear
		n.sts = n.sts | fall;
		// Runtime interrupt with re-arm on all columns high
		n.irq = (|(r.sts & r.ien)) & (r.irq | r.armed);
		if (r.irq) begin
			n.armed = 1'b0;
		end
		if (&r.col_sync) begin
			n.armed = 1'b1;
		end
		// Wake request while bus clock is stopped
		if (BUS_CLK_STOPPED && |(fall & r.ien)) begin
			n.wake = 1'b1;
		end else if (!BUS_CLK_STOPPED) begin
			n.wake = 1'b0;
		end
		// Row drive and predrive of released rows
		n.low = tgt;
		if (r.dis) begin
			n.pd_rows = 18'h00000;
			n.pd_cnt = 2'h0;
		end else if (r.pd_en && |rel) begin
			n.pd_rows = (r.pd_rows | rel) & ~tgt;
			n.pd_cnt = PD_CYC;
		end else if (r.pd_cnt != 2'h0) begin
			n.pd_rows = r.pd_rows & ~tgt;
			n.pd_cnt = r.pd_cnt - 2'h1;
		end else begin
			n.pd_rows = 18'h00000;
		end
		n.oe = tgt | n.pd_rows;
		n.out = n.pd_rows;
		// Power state follows activity
		if (r.dis) begin
			n.st = ST_LP;
		end else if (|n.pd_rows) begin
			n.st = ST_PRED;
		end else if (|tgt) begin
			n.st = ST_SCAN;
		end else begin
			n.st = ST_LP;
		end
		// Read data captured in the setup phase
		if (PSEL && !PENABLE && !PWRITE) begin
			case (PADDR)
				OFS_ROW_SEL: n.rdata = {24'h000000, r.inv, r.dis, r.all, r.sel};
				OFS_COL_IN:  n.rdata = {24'h000000, r.col_sync};
				OFS_COL_STS: n.rdata = {24'h000000, r.sts};
				OFS_COL_IEN: n.rdata = {24'h000000, r.ien};
				OFS_EXT_CTL: n.rdata = {31'h00000000, r.pd_en};
				default:     n.rdata = 32'h00000000;
			endcase
		end
	end

	// State register, all fields to defaults on reset
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			r <= '{st: ST_LP, col_meta: 8'hFF, col_sync: 8'hFF, col_prev: 8'hFF,
				sel: RST_SEL, all: 1'b0, dis: RST_DIS, inv: 1'b0, pd_en: 1'b0,
				sts: 8'h00, ien: RST_IEN, irq: 1'b0, armed: 1'b1, wake: 1'b0,
				low: 18'h00000, pd_rows: 18'h00000, pd_cnt: 2'h0,
				rdata: 32'h00000000, out: 18'h00000, oe: 18'h00000};
		end else begin
			r <= n;
		end
	end

	// Outputs from flops
	assign PRDATA = r.rdata;
	assign ROW_DRIVE_OUT = r.out;
	assign ROW_DRIVE_OE = r.oe;
	assign SCAN_RUNTIME_IRQ = r.irq;
	assign SCAN_WAKE_IRQ = r.wake;

	AST_STS_SET: assert property (@(posedge CORE_CLK) disable iff (RESET)
		##1 ((r.sts & $past(fall)) == $past(fall)))
		else $error("status bit missed a falling edge");

	AST_IRQ_CAUSE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		r.irq |-> $past(|(r.sts & r.ien)))
		else $error("runtime irq without enabled status");

	AST_IRQ_REARM: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!r.irq && !r.armed) |=> !r.irq)
		else $error("runtime irq reasserted before columns high");

	AST_WAKE_SET: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(BUS_CLK_STOPPED && |(fall & r.ien)) |=> SCAN_WAKE_IRQ)
		else $error("wake not raised on enabled edge");

	AST_WAKE_CLR: assert property (@(posedge CORE_CLK) disable iff (RESET)
		!BUS_CLK_STOPPED |=> !SCAN_WAKE_IRQ)
		else $error("wake held with clock running");

	AST_DIS_LP: assert property (@(posedge CORE_CLK) disable iff (RESET)
		r.dis |=> (r.st == ST_LP) && (ROW_DRIVE_OE == 18'h00000))
		else $error("disabled block not in low power");

	AST_DRIVE_INHIBIT: assert property (@(posedge CORE_CLK) disable iff (RESET)
		|(ROW_DRIVE_OE & ~ROW_DRIVE_OUT) |-> SLEEP_INHIBIT)
		else $error("row driven low without sleep inhibit");

	AST_PREDRIVE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(r.pd_en && !r.dis && |rel) |=>
		((ROW_DRIVE_OE & ROW_DRIVE_OUT & $past(rel)) == $past(rel & ~tgt)))
		else $error("released row not predriven high");

	AST_DIS_NO_LOW: assert property (@(posedge CORE_CLK) disable iff (RESET)
		r.dis |-> (tgt == 18'h00000))
		else $error("disabled block selects a row");

	AST_LP_NO_DRIVE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(r.st == ST_LP) |-> (ROW_DRIVE_OE == 18'h00000))
		else $error("low power state with rows driven");

	AST_LP_NO_INHIBIT: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(r.st == ST_LP) |-> !SLEEP_INHIBIT)
		else $error("sleep inhibited in low power");

	AST_SCAN_INHIBIT: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(r.st == ST_SCAN) |-> SLEEP_INHIBIT)
		else $error("scanning without sleep inhibit");

	AST_ONE_ROW: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!r.dis && !r.all && !r.inv && (r.sel <= ROW_MAX)) |=> $onehot(r.low))
		else $error("single row select drives other rows");

	AST_INV_NONE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!r.dis && r.inv && (r.sel <= ROW_MAX)) |=> (r.low == 18'h00000))
		else $error("inverted select still drives a row low");

	AST_ALL_LOW: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!r.dis && r.all && !r.inv && (r.sel <= ROW_MAX)) |=> (r.low == 18'h3FFFF))
		else $error("all rows select missed a row");

	AST_OVER_INV: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!r.dis && r.inv && (r.sel > ROW_MAX)) |=> (r.low == 18'h3FFFF))
		else $error("over range inverted select missed a row");

	AST_LOW_ROWS: assert property (@(posedge CORE_CLK) disable iff (RESET)
		##1 ((ROW_DRIVE_OE & ~ROW_DRIVE_OUT) == $past(tgt)))
		else $error("rows driven low differ from selection");

	AST_OUT_IN_OE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		((ROW_DRIVE_OUT & ~ROW_DRIVE_OE) == 18'h00000))
		else $error("row high value without output enable");

	AST_NO_PD_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!r.pd_en && (r.pd_cnt == 2'h0)) |=> ((ROW_DRIVE_OE & ROW_DRIVE_OUT) == 18'h00000))
		else $error("row driven high without predrive");

	AST_PD_CNT_MAX: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(r.pd_cnt <= PD_CYC))
		else $error("predrive counter above its load value");

	AST_PD_END: assert property (@(posedge CORE_CLK) disable iff (RESET)
		((r.pd_cnt == 2'h0) && !(r.pd_en && |rel)) |=> (r.pd_rows == 18'h00000))
		else $error("predrive outlasted its count");

	AST_PRED_STATE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(|r.pd_rows) |-> (r.st == ST_PRED))
		else $error("predriving outside predrive state");

	AST_ST_ONEHOT: assert property (@(posedge CORE_CLK) disable iff (RESET)
		$onehot(r.st))
		else $error("power state not one hot");

	AST_IRQ_DROP: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(r.irq && !(|(r.sts & r.ien))) |=> !r.irq)
		else $error("runtime irq held without enabled status");

	AST_IRQ_RISE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		$rose(r.irq) |-> $past(r.armed))
		else $error("runtime irq raised while not armed");

	AST_STS_CLEAR: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(wr && (PADDR == OFS_COL_STS)) |=> ((r.sts & $past(PWDATA[7:0] & ~fall)) == 8'h00))
		else $error("status bit survived write one clear");

	AST_STS_HOLD: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!(wr && (PADDR == OFS_COL_STS)) && (fall == 8'h00)) |=> (r.sts == $past(r.sts)))
		else $error("status changed without edge or clear");

	AST_IEN_WRITE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(wr && (PADDR == OFS_COL_IEN)) |=> (r.ien == $past(PWDATA[7:0])))
		else $error("interrupt enable write lost");

	AST_WAKE_HOLD: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(BUS_CLK_STOPPED && r.wake) |=> r.wake)
		else $error("wake dropped while clock stopped");

	AST_WAKE_CAUSE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		$rose(r.wake) |-> $past(BUS_CLK_STOPPED))
		else $error("wake raised with clock running");

	AST_SYNC_STAGE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		##1 (r.col_sync == $past(r.col_meta)))
		else $error("second synchroniser stage skipped");

	AST_PREV_STAGE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		##1 (r.col_prev == $past(r.col_sync)))
		else $error("edge detect stage skipped");

	AST_RD_COLIN: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(PSEL && !PENABLE && !PWRITE && (PADDR == OFS_COL_IN)) |=>
		(PRDATA == {24'h000000, $past(r.col_sync)}))
		else $error("column read data wrong");

	AST_DIS_WRITE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(wr && (PADDR == OFS_ROW_SEL)) |=> (r.dis == $past(PWDATA[POS_DIS])))
		else $error("scan disable write lost");

	AST_PD_EN_WRITE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(wr && (PADDR == OFS_EXT_CTL)) |=> (r.pd_en == $past(PWDATA[POS_PD_EN])))
		else $error("predrive enable write lost");

	AST_SYNC_LAT: assert property (@(posedge CORE_CLK) disable iff (RESET)
		##3 (r.col_sync == $past(COLUMN_SENSE_IN, 2)))
		else $error("column synchroniser latency wrong");

	AST_BAD_ADDR: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(PSEL && PENABLE && !addr_ok(PADDR)) |-> PSLVERR)
		else $error("unmapped access without error");
endmodule : kbs_scan
`default_nettype wire

// file: test_keyboard_matrix_scan.sv
`default_nettype none
module test_keyboard_matrix_scan
	import kbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, psel, penable, pwrite, stopped, key_down;
	logic        pready, pslverr, err, wake, irq, inhibit;
	logic [7:0]  paddr, col;
	logic [31:0] pwdata, prdata, q;
	logic [17:0] rout, roe;
	logic [4:0]  key_row;
	logic [2:0]  key_col;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cycles = 0;

	kbs_scan u_kbs_scan (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .COLUMN_SENSE_IN(col),
		.ROW_DRIVE_OUT(rout), .ROW_DRIVE_OE(roe), .BUS_CLK_STOPPED(stopped),
		.SCAN_RUNTIME_IRQ(irq), .SCAN_WAKE_IRQ(wake), .SLEEP_INHIBIT(inhibit));
	kbs_matrix u_kbs_matrix (.row_out(rout), .row_oe(roe), .key_row(key_row),
		.key_col(key_col), .key_down(key_down), .col_out(col));

	// 20 MHz core clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic print_verdict();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// Main sequence
	initial begin
		{rst, psel, penable, pwrite, stopped, key_down} = 6'h20;
		{paddr, pwdata, key_row, key_col} = '0;
		tick(6);
		rst <= 1'b0;
		apb(1'b0, OFS_ROW_SEL, 32'h0);
		chk("row_sel", 32'h40, q);
		chk("row_oe", 32'h0, 32'(roe));
		chk("inhibit", 32'h0, 32'(inhibit));
		apb(1'b0, 8'h00, 32'h0);
		chk("unmapped", 32'h0, q);
		chk("pslverr", 32'h1, 32'(err));
		// Scan row 3 with key at column 2 held
		apb(1'b1, OFS_COL_IEN, 32'h04);
		key_row  <= 5'h03;
		key_col  <= 3'h2;
		key_down <= 1'b1;
		apb(1'b1, OFS_ROW_SEL, 32'h03);
		tick(10);
		chk("row_oe", 32'h8, 32'(roe));
		chk("row_out", 32'h0, 32'(rout));
		chk("inhibit", 32'h1, 32'(inhibit));
		apb(1'b0, OFS_COL_IN, 32'h0);
		chk("col_in", 32'hFB, q);
		apb(1'b0, OFS_COL_IN, 32'h0);
		chk("col_in_again", 32'hFB, q);
		apb(1'b0, OFS_COL_STS, 32'h0);
		chk("col_sts", 32'h04, q);
		chk("irq", 32'h1, 32'(irq));
		apb(1'b1, OFS_COL_STS, 32'h04);
		tick(3);
		chk("irq", 32'h0, 32'(irq));
		apb(1'b0, OFS_COL_STS, 32'h0);
		chk("col_sts", 32'h0, q);
		// Release, then press again with the bus clock stopped
		key_down <= 1'b0;
		tick(6);
		stopped  <= 1'b1;
		key_down <= 1'b1;
		tick(8);
		chk("wake", 32'h1, 32'(wake));
		stopped <= 1'b0;
		tick(3);
		chk("wake", 32'h0, 32'(wake));
		chk("irq", 32'h1, 32'(irq));
		// All rows, then disable
		apb(1'b1, OFS_ROW_SEL, 32'h20);
		tick(3);
		chk("row_oe", 32'h3FFFF, 32'(roe));
		apb(1'b1, OFS_ROW_SEL, 32'h40);
		tick(3);
		chk("row_oe", 32'h0, 32'(roe));
		chk("inhibit", 32'h0, 32'(inhibit));
		// Predrive entry order, then move from row 3 to row 5
		apb(1'b1, OFS_EXT_CTL, 32'h1);
		apb(1'b1, OFS_ROW_SEL, 32'h03);
		tick(3);
		apb(1'b1, OFS_ROW_SEL, 32'h05);
		tick(3);
		chk("predrive", 32'h3, 32'({roe[3], rout[3]}));
		tick(6);
		chk("row_oe", 32'h20, 32'(roe));
		// Predrive exit order, then the same move releases with no high drive
		apb(1'b1, OFS_ROW_SEL, 32'h40);
		apb(1'b1, OFS_EXT_CTL, 32'h0);
		apb(1'b1, OFS_ROW_SEL, 32'h03);
		tick(3);
		apb(1'b1, OFS_ROW_SEL, 32'h05);
		tick(3);
		chk("no_predrive", 32'h20, 32'(roe));
		print_verdict();
	end
endmodule : test_keyboard_matrix_scan
`default_nettype wire
